/* File: core/dcmp_pkg.sv */
package dcmp_pkg;

  // ------------
  // Mode page codes
  // ------------
  localparam logic [5:0] PAGE_RW_ERR_RECOVERY = 6'h01;
  localparam logic [5:0] PAGE_FLEXIBLE_DISK = 6'h05;
  localparam logic [5:0] PAGE_CACHING = 6'h08;
  localparam logic [5:0] PAGE_CONTROL = 6'h0a;
  localparam logic [5:0] PAGE_RETURN_ALL = 6'h3f;
  localparam logic [5:0] PAGE_VENDOR_LO = 6'h20;

  // ------------
  // Caching page byte offsets
  // ------------
  localparam logic [3:0] OFS_HEADER = 4'h0;
  localparam logic [3:0] OFS_LENGTH = 4'h1;
  localparam logic [3:0] OFS_FLAGS = 4'h2;
  localparam logic [3:0] OFS_RETENTION = 4'h3;
  localparam logic [3:0] OFS_DISABLE_HI = 4'h4;
  localparam logic [3:0] OFS_DISABLE_LO = 4'h5;
  localparam logic [3:0] OFS_MIN_HI = 4'h6;
  localparam logic [3:0] OFS_MIN_LO = 4'h7;
  localparam logic [3:0] OFS_MAX_HI = 4'h8;
  localparam logic [3:0] OFS_MAX_LO = 4'h9;
  localparam logic [3:0] OFS_CEIL_HI = 4'ha;
  localparam logic [3:0] OFS_CEIL_LO = 4'hb;
  localparam logic [7:0] CACHING_PAGE_LEN = 8'h0a;

  // ------------
  // Field positions
  // ------------
  localparam int BIT_SAVABLE = 7;
  localparam int BIT_WRITE_CACHE_ON = 2;
  localparam int BIT_PREFETCH_SCALE = 1;
  localparam int BIT_READ_CACHE_OFF = 0;
  localparam int BIT_HINT_SUPPORT = 4;

  // ------------
  // Reset values (power-on defaults)
  // ------------
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [7:0] RST_RETENTION = 8'h00;
  localparam logic [15:0] RST_DISABLE = 16'h0000;
  localparam logic [15:0] RST_MIN = 16'h0000;
  localparam logic [15:0] RST_MAX = 16'h0000;
  localparam logic [15:0] RST_CEIL = 16'h0000;
  localparam logic [7:0] RST_DENSITY = 8'h00;

  // ------------
  // Retention priority encodings
  // ------------
  localparam logic [3:0] RET_EQUAL = 4'h0;
  localparam logic [3:0] RET_LOWER = 4'h1;
  localparam logic [3:0] RET_HIGHER = 4'hf;

  // Decoded page selected by a command
  typedef enum logic [2:0] {
    DCMP_PG_NONE = 3'b000,
    DCMP_PG_CACHING = 3'b001,
    DCMP_PG_CONTROL = 3'b011,
    DCMP_PG_RW_ERR = 3'b010,
    DCMP_PG_FLEX = 3'b110,
    DCMP_PG_ALL = 3'b111,
    DCMP_PG_VENDOR = 3'b101,
    DCMP_PG_RSVD = 3'b100
  } dcmp_page_t;

  // Retention class advice handed to the cache manager
  typedef enum logic [1:0] {
    DCMP_RET_EQUAL = 2'b00,
    DCMP_RET_LOWER = 2'b01,
    DCMP_RET_HIGHER = 2'b11,
    DCMP_RET_RSVD = 2'b10
  } dcmp_ret_t;

  // Prefetch advice for one read command
  typedef struct packed {
    logic enable;
    logic [31:0] min_blocks;
    logic [31:0] max_blocks;
  } dcmp_prefetch_t;

  // Stored prefetch fields of the caching page
  typedef struct packed {
    logic [15:0] disable_len;
    logic [15:0] minimum;
    logic [15:0] maximum;
    logic [15:0] ceiling;
  } dcmp_pf_fields_t;

endpackage

/* File: core/dcmp_prefetch_calc.sv */
`timescale 1ns/1ps

module dcmp_prefetch_calc (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rd_start,
  input wire logic [15:0] rd_xfer_len,
  input wire logic scale,
  input wire dcmp_pkg::dcmp_pf_fields_t fields,
  output dcmp_pkg::dcmp_prefetch_t advice
);

  // ------------
  // Scaling helper
  // ------------
  // Plain count or multiple of the transfer length
  function automatic logic [31:0] scaled(
    input logic [15:0] val,
    input logic [15:0] len,
    input logic mul
  );
    scaled = mul ? val * len : {16'h0000, val};
  endfunction

  logic [31:0] next_min; // Minimum blocks for this read
  logic [31:0] next_max; // Maximum blocks after ceiling
  logic [31:0] ceil32; // Ceiling widened

  always_comb begin
    next_min = scaled(fields.minimum, rd_xfer_len, scale);
    next_max = scaled(fields.maximum, rd_xfer_len, scale);
    ceil32 = {16'h0000, fields.ceiling};
    // Ceiling clips the maximum; matters mostly when scaling is on
    if (next_max > ceil32) begin
      next_max = ceil32;
    end
  end

  // ------------
  // Result register, updated once per read command
  // ------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      advice <= '0;
    end else if (rd_start) begin
      // Zero disable length turns every prefetch off
      advice.enable <= (fields.disable_len != 16'h0000) &&
                       (rd_xfer_len <= fields.disable_len);
      advice.min_blocks <= next_min;
      advice.max_blocks <= next_max;
    end
  end

endmodule

/* File: core/dcmp_mode_pages.sv */
`timescale 1ns/1ps

// Overview of operation
// - Select ignores cache-hint flag header bit
// - Sense reports cache-hint flag from support strap
// - Density code reserved, reads zero, writes ignored
// - Decode page codes 08h, 0Ah, 01h, 05h
// - Return-all page code only valid for sense
// - Zero notch means whole unit, else notch
// - Page 08h controls the data cache
// - Savable flag sense-only, reserved on select
// - Savable page saved when save-pages flag set
// - Write cache off: status after medium write
// - Write cache on: status after data received
// - Scale clear: prefetch fields are block counts
// - Scale set: prefetch times transfer length
// - Read cache on: cache or medium allowed
// - Read cache off: always read medium
// - Retention fields share encoding, 2h-Eh reserved
// - Retention 0h: equal with other data
// - Retention 1h: evict sooner than others
// - Retention Fh: keep while others replaceable
// - Write retention covers data already on medium
module dcmp_mode_pages #(
  parameter bit SAVABLE = 1'b1, // Non-volatile page store present
  parameter bit HINT_SUPPORT = 1'b1, // Honours DPO and FUA bits
  parameter bit NOTCH_SUPPORT = 1'b0, // Notch page implemented
  parameter int NOTCH_W = 8 // Width of the active notch value
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_start,
  input wire logic cmd_is_select,
  input wire logic [5:0] cmd_page_code,
  input wire logic cmd_save_pages,
  input wire logic [NOTCH_W-1:0] active_notch,
  input wire logic sel_valid,
  input wire logic [3:0] sel_index,
  input wire logic [7:0] sel_byte,
  input wire logic [7:0] sel_hdr_dev_param,
  input wire logic [7:0] sel_density,
  input wire logic sel_done,
  input wire logic sns_req,
  input wire logic [3:0] sns_index,
  input wire logic wr_received,
  input wire logic wr_medium_done,
  input wire logic rd_start,
  input wire logic [15:0] rd_xfer_len,
  input wire logic rd_cache_hit,
  output dcmp_pkg::dcmp_page_t page_kind,
  output logic cmd_reject,
  output logic [7:0] sns_byte,
  output logic sns_valid,
  output logic [7:0] sns_hdr_dev_param,
  output logic [7:0] sns_density,
  output logic scope_whole_unit,
  output logic [NOTCH_W-1:0] scope_notch,
  output logic save_req,
  output logic wr_good_status,
  output logic rd_use_cache,
  output dcmp_pkg::dcmp_ret_t read_retention,
  output dcmp_pkg::dcmp_ret_t write_retention,
  output dcmp_pkg::dcmp_prefetch_t prefetch
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (NOTCH_W < 1 || NOTCH_W > 16) begin : g_bad_notch
    $error("NOTCH_W must lie between 1 and 16");
  end

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Page code to page kind
  function automatic dcmp_pkg::dcmp_page_t decode_page(
    input logic [5:0] code
  );
    case (code)
      dcmp_pkg::PAGE_CACHING: decode_page = dcmp_pkg::DCMP_PG_CACHING;
      dcmp_pkg::PAGE_CONTROL: decode_page = dcmp_pkg::DCMP_PG_CONTROL;
      dcmp_pkg::PAGE_RW_ERR_RECOVERY: decode_page = dcmp_pkg::DCMP_PG_RW_ERR;
      dcmp_pkg::PAGE_FLEXIBLE_DISK: decode_page = dcmp_pkg::DCMP_PG_FLEX;
      dcmp_pkg::PAGE_RETURN_ALL: decode_page = dcmp_pkg::DCMP_PG_ALL;
      default: begin
        // Upper codes belong to vendors, the rest are reserved
        if (code >= dcmp_pkg::PAGE_VENDOR_LO) begin
          decode_page = dcmp_pkg::DCMP_PG_VENDOR;
        end else begin
          decode_page = dcmp_pkg::DCMP_PG_RSVD;
        end
      end
    endcase
  endfunction

  // Retention nibble to advice class
  function automatic dcmp_pkg::dcmp_ret_t decode_ret(
    input logic [3:0] val
  );
    case (val)
      dcmp_pkg::RET_EQUAL: decode_ret = dcmp_pkg::DCMP_RET_EQUAL;
      dcmp_pkg::RET_LOWER: decode_ret = dcmp_pkg::DCMP_RET_LOWER;
      dcmp_pkg::RET_HIGHER: decode_ret = dcmp_pkg::DCMP_RET_HIGHER;
      default: decode_ret = dcmp_pkg::DCMP_RET_RSVD;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Caching page storage
  // ---------------------------------------------------------------
  logic write_cache_on; // Early write status allowed
  logic prefetch_scale_flag; // Prefetch fields are multipliers
  logic read_cache_off; // Reads bypass the cache
  logic [7:0] retention_priorities; // Read nibble high, write low
  dcmp_pkg::dcmp_pf_fields_t pf; // Prefetch fields
  logic sel_active; // A select of the caching page runs
  logic sel_save; // Save-pages flag of the running select
  dcmp_pkg::dcmp_page_t next_kind; // Decoded code of this command

  assign next_kind = decode_page(cmd_page_code);

  // Command decode and return-all refusal on select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page_kind <= dcmp_pkg::DCMP_PG_NONE;
      cmd_reject <= 1'b0;
    end else begin
      cmd_reject <= 1'b0;
      if (cmd_start) begin
        page_kind <= next_kind;
        // Return-all cannot be written
        if (cmd_is_select && next_kind == dcmp_pkg::DCMP_PG_ALL) begin
          cmd_reject <= 1'b1;
        end
      end
    end
  end

  // Track a select aimed at the caching page
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_active <= 1'b0;
      sel_save <= 1'b0;
    end else if (cmd_start) begin
      sel_active <= cmd_is_select &&
                    next_kind == dcmp_pkg::DCMP_PG_CACHING;
      sel_save <= cmd_is_select && cmd_save_pages;
    end else if (sel_done) begin
      sel_active <= 1'b0;
    end
  end

  // Scope of the parameters, latched when a select starts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scope_whole_unit <= 1'b1;
      scope_notch <= '0;
    end else if (cmd_start && cmd_is_select) begin
      // Notch value only counts when the notch page exists
      if (!NOTCH_SUPPORT || active_notch == '0) begin
        scope_whole_unit <= 1'b1;
        scope_notch <= '0;
      end else begin
        scope_whole_unit <= 1'b0;
        scope_notch <= active_notch;
      end
    end
  end

  // Page bytes written by select; header, length and
  // the savable bit are not writable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_cache_on <= dcmp_pkg::RST_FLAGS[dcmp_pkg::BIT_WRITE_CACHE_ON];
      prefetch_scale_flag <=
        dcmp_pkg::RST_FLAGS[dcmp_pkg::BIT_PREFETCH_SCALE];
      read_cache_off <= dcmp_pkg::RST_FLAGS[dcmp_pkg::BIT_READ_CACHE_OFF];
      retention_priorities <= dcmp_pkg::RST_RETENTION;
      pf.disable_len <= dcmp_pkg::RST_DISABLE;
      pf.minimum <= dcmp_pkg::RST_MIN;
      pf.maximum <= dcmp_pkg::RST_MAX;
      pf.ceiling <= dcmp_pkg::RST_CEIL;
    end else if (sel_valid && sel_active) begin
      case (sel_index)
        // Savable bit in byte 0 is reserved on select
        dcmp_pkg::OFS_HEADER: ;
        dcmp_pkg::OFS_FLAGS: begin
          write_cache_on <= sel_byte[dcmp_pkg::BIT_WRITE_CACHE_ON];
          prefetch_scale_flag <= sel_byte[dcmp_pkg::BIT_PREFETCH_SCALE];
          read_cache_off <= sel_byte[dcmp_pkg::BIT_READ_CACHE_OFF];
        end
        dcmp_pkg::OFS_RETENTION: retention_priorities <= sel_byte;
        dcmp_pkg::OFS_DISABLE_HI: pf.disable_len[15:8] <= sel_byte;
        dcmp_pkg::OFS_DISABLE_LO: pf.disable_len[7:0] <= sel_byte;
        dcmp_pkg::OFS_MIN_HI: pf.minimum[15:8] <= sel_byte;
        dcmp_pkg::OFS_MIN_LO: pf.minimum[7:0] <= sel_byte;
        dcmp_pkg::OFS_MAX_HI: pf.maximum[15:8] <= sel_byte;
        dcmp_pkg::OFS_MAX_LO: pf.maximum[7:0] <= sel_byte;
        dcmp_pkg::OFS_CEIL_HI: pf.ceiling[15:8] <= sel_byte;
        dcmp_pkg::OFS_CEIL_LO: pf.ceiling[7:0] <= sel_byte;
        default: ; // Length byte and indices past the page end are ignored
      endcase
    end
  end

  // Save request to the non-volatile store at the end of a select.
  // Without a store the save flag is simply ignored here.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      save_req <= 1'b0;
    end else begin
      save_req <= sel_done && sel_active && sel_save && SAVABLE;
    end
  end

  // ---------------------------------------------------------------
  // Sense read-back, one cycle after the request
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sns_byte <= 8'h00;
      sns_valid <= 1'b0;
    end else begin
      sns_valid <= sns_req;
      if (sns_req) begin
        case (sns_index)
          dcmp_pkg::OFS_HEADER: begin
            sns_byte <= {2'b00, dcmp_pkg::PAGE_CACHING};
            sns_byte[dcmp_pkg::BIT_SAVABLE] <= SAVABLE;
          end
          dcmp_pkg::OFS_LENGTH: sns_byte <= dcmp_pkg::CACHING_PAGE_LEN;
          dcmp_pkg::OFS_FLAGS: sns_byte <= {5'h00, write_cache_on,
            prefetch_scale_flag, read_cache_off};
          dcmp_pkg::OFS_RETENTION: sns_byte <= retention_priorities;
          dcmp_pkg::OFS_DISABLE_HI: sns_byte <= pf.disable_len[15:8];
          dcmp_pkg::OFS_DISABLE_LO: sns_byte <= pf.disable_len[7:0];
          dcmp_pkg::OFS_MIN_HI: sns_byte <= pf.minimum[15:8];
          dcmp_pkg::OFS_MIN_LO: sns_byte <= pf.minimum[7:0];
          dcmp_pkg::OFS_MAX_HI: sns_byte <= pf.maximum[15:8];
          dcmp_pkg::OFS_MAX_LO: sns_byte <= pf.maximum[7:0];
          dcmp_pkg::OFS_CEIL_HI: sns_byte <= pf.ceiling[15:8];
          dcmp_pkg::OFS_CEIL_LO: sns_byte <= pf.ceiling[7:0];
          default: sns_byte <= 8'h00; // Past the page end
        endcase
      end
    end
  end

  // Header byte and density for sense; select copies are
  // accepted on the ports but never stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sns_hdr_dev_param <= 8'h00;
      sns_density <= dcmp_pkg::RST_DENSITY;
    end else begin
      sns_hdr_dev_param <= 8'h00;
      sns_hdr_dev_param[dcmp_pkg::BIT_HINT_SUPPORT] <= HINT_SUPPORT;
      sns_density <= dcmp_pkg::RST_DENSITY;
    end
  end

  // Select header and density inputs carry nothing for this target
  logic unused_sel; // Collects ignored select fields
  assign unused_sel = ^{sel_hdr_dev_param, sel_density};

  // ---------------------------------------------------------------
  // Cache behaviour steered by the page
  // ---------------------------------------------------------------
  // Write completion status; with the cache off, the received
  // pulse is ignored and only the medium completion counts
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_good_status <= 1'b0;
    end else if (write_cache_on) begin
      wr_good_status <= wr_received;
    end else begin
      wr_good_status <= wr_medium_done;
    end
  end

  // Read source: hit only used while the read cache is on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_use_cache <= 1'b0;
    end else if (rd_start) begin
      rd_use_cache <= rd_cache_hit && !read_cache_off;
    end
  end

  // Retention advice, write field covers data already on medium
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      read_retention <= dcmp_pkg::DCMP_RET_EQUAL;
      write_retention <= dcmp_pkg::DCMP_RET_EQUAL;
    end else begin
      read_retention <= decode_ret(retention_priorities[7:4]);
      write_retention <= decode_ret(retention_priorities[3:0]);
    end
  end

  // Prefetch sizing per read command
  dcmp_prefetch_calc u_prefetch (
    .mclk(mclk),
    .rst_n(rst_n),
    .rd_start(rd_start),
    .rd_xfer_len(rd_xfer_len),
    .scale(prefetch_scale_flag),
    .fields(pf),
    .advice(prefetch)
  );

endmodule

/* File: verification/dcmp_init_model.sv */
`timescale 1ns/1ps

// ------------
// Initiator model: opens mode commands, sends and reads page bytes
// ------------
module dcmp_init_model (
  input wire logic mclk,
  input wire logic [7:0] sns_byte,
  input wire logic sns_valid,
  output logic cmd_start,
  output logic cmd_is_select,
  output logic [5:0] cmd_page_code,
  output logic cmd_save_pages,
  output logic sel_valid,
  output logic [3:0] sel_index,
  output logic [7:0] sel_byte,
  output logic sel_done,
  output logic sns_req,
  output logic [3:0] sns_index
);
  // Quiet bus at time zero
  initial begin
    {cmd_start, cmd_is_select, cmd_save_pages} = 3'h0;
    {sel_valid, sel_done, sns_req} = 3'h0;
    cmd_page_code = 6'h00;
    {sel_index, sns_index, sel_byte} = 16'h0000;
  end

  // Code 3Fh goes with a select only where a refusal is wanted
  task automatic cmd(input logic sel, input logic [5:0] code,
      input logic save);
    @(negedge mclk);
    cmd_start = 1'b1;
    cmd_is_select = sel;
    cmd_page_code = code;
    cmd_save_pages = save;
    @(negedge mclk);
    cmd_start = 1'b0;
    cmd_page_code = ~code; // Released field shows no stale value
  endtask

  // One page byte; index and data are scrambled once released
  task automatic wb(input logic [3:0] idx, input logic [7:0] b);
    @(negedge mclk);
    sel_valid = 1'b1;
    sel_index = idx;
    sel_byte = b;
    @(negedge mclk);
    sel_valid = 1'b0;
    sel_index = ~idx;
    sel_byte = ~b;
  endtask

  // Sixteen-bit field, high byte first
  task automatic w16(input logic [3:0] idx, input logic [15:0] v);
    wb(idx, v[15:8]);
    wb(idx + 4'h1, v[7:0]);
  endtask

  task automatic done;
    @(negedge mclk);
    sel_done = 1'b1;
    @(negedge mclk);
    sel_done = 1'b0;
  endtask

  // Answer is sampled in the one cycle that it stands
  task automatic sense(input logic [3:0] idx, output logic [8:0] r);
    @(negedge mclk);
    sns_req = 1'b1;
    sns_index = idx;
    @(negedge mclk);
    sns_req = 1'b0;
    sns_index = ~idx;
    r = {sns_valid, sns_byte};
  endtask
endmodule

/* File: verification/dcmp_mode_pages_chk.sv */
`timescale 1ns/1ps

// ------------
// Port checker for the mode page block
// ------------
module dcmp_mode_pages_chk #(
  parameter bit SAVABLE = 1'b1,
  parameter bit HINT_SUPPORT = 1'b1,
  parameter bit NOTCH_SUPPORT = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmd_start,
  input wire logic cmd_is_select,
  input wire logic [5:0] cmd_page_code,
  input wire logic sel_done,
  input wire logic wr_received,
  input wire logic wr_medium_done,
  input wire logic rd_start,
  input wire dcmp_pkg::dcmp_page_t page_kind,
  input wire logic cmd_reject,
  input wire logic [7:0] sns_hdr_dev_param,
  input wire logic [7:0] sns_density,
  input wire logic scope_whole_unit,
  input wire logic save_req,
  input wire logic wr_good_status,
  input wire dcmp_pkg::dcmp_prefetch_t prefetch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_reject;
    cmd_start && cmd_is_select && cmd_page_code == 6'h3f |=> cmd_reject;
  endproperty
  a_reject: assert property (p_reject)
    else $error("select of all pages not refused");
  property p_sense_all;
    cmd_start && !cmd_is_select && cmd_page_code == 6'h3f |=>
      page_kind == dcmp_pkg::DCMP_PG_ALL && !cmd_reject;
  endproperty
  a_sense_all: assert property (p_sense_all)
    else $error("sense of all pages mishandled");
  property p_caching;
    cmd_start && cmd_page_code == 6'h08 |=>
      page_kind == dcmp_pkg::DCMP_PG_CACHING;
  endproperty
  a_caching: assert property (p_caching)
    else $error("caching page code not decoded");
  property p_control;
    cmd_start && cmd_page_code == 6'h0a |=>
      page_kind == dcmp_pkg::DCMP_PG_CONTROL;
  endproperty
  a_control: assert property (p_control)
    else $error("control page code not decoded");
  // First edge after release still sees the reset value
  property p_hint;
    $past(rst_n) |-> sns_hdr_dev_param == {3'h0, HINT_SUPPORT, 4'h0};
  endproperty
  a_hint: assert property (p_hint)
    else $error("hint support flag misreported");
  property p_density;
    sns_density == 8'h00;
  endproperty
  a_density: assert property (p_density)
    else $error("density code not zero");
  property p_scope;
    !NOTCH_SUPPORT |-> scope_whole_unit;
  endproperty
  a_scope: assert property (p_scope)
    else $error("scope not whole unit");
  property p_save;
    save_req |-> $past(sel_done) && SAVABLE;
  endproperty
  a_save: assert property (p_save)
    else $error("save without end of select data");
  property p_wr;
    wr_good_status |-> $past(wr_received) || $past(wr_medium_done);
  endproperty
  a_wr: assert property (p_wr)
    else $error("good status without a write event");
  property p_pf_hold;
    !rd_start |=> $stable(prefetch);
  endproperty
  a_pf_hold: assert property (p_pf_hold)
    else $error("prefetch advice moved without a read");

  // Main scenarios reached
  c_reject: cover property (cmd_reject);
  c_save: cover property (save_req);
  c_wr: cover property (wr_good_status);
endmodule

bind dcmp_mode_pages dcmp_mode_pages_chk #(.SAVABLE(SAVABLE),
  .HINT_SUPPORT(HINT_SUPPORT), .NOTCH_SUPPORT(NOTCH_SUPPORT)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .cmd_start(cmd_start),
  .cmd_is_select(cmd_is_select), .cmd_page_code(cmd_page_code),
  .sel_done(sel_done), .wr_received(wr_received),
  .wr_medium_done(wr_medium_done), .rd_start(rd_start),
  .page_kind(page_kind), .cmd_reject(cmd_reject),
  .sns_hdr_dev_param(sns_hdr_dev_param), .sns_density(sns_density),
  .scope_whole_unit(scope_whole_unit), .save_req(save_req),
  .wr_good_status(wr_good_status), .prefetch(prefetch));

/* File: verification/testbench.sv */
`timescale 1ns/1ps

module testbench;
  // ------------
  // Clock, reset and bench-driven inputs
  // ------------
  logic mclk = 1'b0; // 250 MHz
  logic rst_n = 1'b0;
  logic [7:0] notch = 8'h03; // Nonzero, yet notches are absent
  logic [7:0] hdr_in = 8'hff; // Header copy must be ignored
  logic [7:0] den_in = 8'h5a; // Density copy must be ignored
  logic wr_rcv = 1'b0, wr_med = 1'b0, rd_st = 1'b0, rd_hit = 1'b0;
  logic [15:0] rd_len = 16'h0000;
  logic cmd_start, cmd_is_sel, cmd_save, sel_valid, sel_done, sns_req;
  logic [5:0] cmd_code;
  logic [3:0] sel_idx, sns_idx;
  logic [7:0] sel_b, sns_b, hdr_o, den_o, notch_o;
  logic sns_v, reject, whole, save_req, wr_good, use_cache;
  dcmp_pkg::dcmp_page_t kind;
  dcmp_pkg::dcmp_ret_t rret, wret;
  dcmp_pkg::dcmp_prefetch_t pf;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] img [12]; // Page image expected back
  logic [8:0] r;

  always #2 mclk = ~mclk;

  dcmp_mode_pages #(.SAVABLE(1'b1), .HINT_SUPPORT(1'b1),
    .NOTCH_SUPPORT(1'b0), .NOTCH_W(8)) i_dcmp_mode_pages (
    .mclk(mclk), .rst_n(rst_n), .cmd_start(cmd_start),
    .cmd_is_select(cmd_is_sel), .cmd_page_code(cmd_code),
    .cmd_save_pages(cmd_save), .active_notch(notch),
    .sel_valid(sel_valid), .sel_index(sel_idx), .sel_byte(sel_b),
    .sel_hdr_dev_param(hdr_in), .sel_density(den_in),
    .sel_done(sel_done), .sns_req(sns_req), .sns_index(sns_idx),
    .wr_received(wr_rcv), .wr_medium_done(wr_med), .rd_start(rd_st),
    .rd_xfer_len(rd_len), .rd_cache_hit(rd_hit), .page_kind(kind),
    .cmd_reject(reject), .sns_byte(sns_b), .sns_valid(sns_v),
    .sns_hdr_dev_param(hdr_o), .sns_density(den_o),
    .scope_whole_unit(whole), .scope_notch(notch_o),
    .save_req(save_req), .wr_good_status(wr_good),
    .rd_use_cache(use_cache), .read_retention(rret),
    .write_retention(wret), .prefetch(pf));

  dcmp_init_model host (
    .mclk(mclk), .sns_byte(sns_b), .sns_valid(sns_v),
    .cmd_start(cmd_start), .cmd_is_select(cmd_is_sel),
    .cmd_page_code(cmd_code), .cmd_save_pages(cmd_save),
    .sel_valid(sel_valid), .sel_index(sel_idx), .sel_byte(sel_b),
    .sel_done(sel_done), .sns_req(sns_req), .sns_index(sns_idx));

  // ------------
  // Comparison and closing
  // ------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, far above the under two hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ------------
  // Scenarios
  // ------------
  // Whole page plus one index past its end, which reads zero
  task automatic t_page;
    for (int i = 0; i < 13; i++) begin
      host.sense(4'(i), r);
      chk("sense byte", {1'b1, (i < 12) ? img[i] : 8'h00}, r);
    end
  endtask

  task automatic t_reset;
    chk("page kind", dcmp_pkg::DCMP_PG_NONE, kind);
    img = '{0: 8'h88, 1: 8'h0a, default: 8'h00};
    t_page();
  endtask

  task automatic t_decode;
    logic [5:0] c [7] = '{6'h08, 6'h0a, 6'h01, 6'h05, 6'h3f, 6'h20, 6'h0d};
    dcmp_pkg::dcmp_page_t k [7] = '{dcmp_pkg::DCMP_PG_CACHING,
      dcmp_pkg::DCMP_PG_CONTROL, dcmp_pkg::DCMP_PG_RW_ERR,
      dcmp_pkg::DCMP_PG_FLEX, dcmp_pkg::DCMP_PG_ALL,
      dcmp_pkg::DCMP_PG_VENDOR, dcmp_pkg::DCMP_PG_RSVD};
    for (int i = 0; i < 7; i++) begin
      host.cmd(1'b0, c[i], 1'b0);
      chk("page kind", k[i], kind);
      chk("refusal", 1'b0, reject);
    end
  endtask

  // Write the caching page, then read it all back
  task automatic t_prog(input logic [7:0] f, rt,
      input logic [15:0] dl, mn, mx, cl, input logic save);
    host.cmd(1'b1, 6'h08, save);
    host.wb(4'h0, 8'h08);
    host.wb(4'h1, 8'h33); // Length is fixed, write is dropped
    host.wb(4'h2, f);
    host.wb(4'h3, rt);
    host.w16(4'h4, dl);
    host.w16(4'h6, mn);
    host.w16(4'h8, mx);
    host.w16(4'ha, cl);
    host.done();
    chk("save request", save, save_req);
    img = '{8'h88, 8'h0a, f & 8'h07, rt, dl[15:8], dl[7:0], mn[15:8],
      mn[7:0], mx[15:8], mx[7:0], cl[15:8], cl[7:0]};
    t_page();
    chk("header", 8'h10, hdr_o);
    chk("density", 8'h00, den_o);
    chk("whole unit", 1'b1, whole);
    chk("active notch", 8'h00, notch_o);
  endtask

  task automatic t_wr(input logic med, rcv, exp);
    @(negedge mclk);
    wr_med = med;
    wr_rcv = rcv;
    @(negedge mclk);
    wr_med = 1'b0;
    wr_rcv = 1'b0;
    chk("good status", exp, wr_good);
  endtask

  task automatic t_rd(input logic [15:0] len, input logic hit, uc, en,
      input logic [31:0] mn, mx);
    @(negedge mclk);
    rd_st = 1'b1;
    rd_len = len;
    rd_hit = hit;
    @(negedge mclk);
    rd_st = 1'b0;
    rd_len = ~len; // Stale length must not leak into the advice
    chk("cache use", uc, use_cache);
    chk("prefetch on", en, pf.enable);
    chk("prefetch min", mn, pf.min_blocks);
    chk("prefetch max", mx, pf.max_blocks);
  endtask

  // A refused select must leave the page untouched
  task automatic t_reject;
    host.cmd(1'b1, 6'h3f, 1'b1);
    chk("refusal", 1'b1, reject);
    host.wb(4'h3, 8'hee);
    host.done();
    chk("save request", 1'b0, save_req);
    host.sense(4'h3, r);
    chk("retention byte", {1'b1, img[3]}, r);
  endtask

  // ------------
  // Main sequence
  // ------------
  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_decode();
    t_prog(8'hff, 8'h1f, 16'h0010, 16'h0003, 16'h0040, 16'h0100,
      1'b1);
    chk("read retention", dcmp_pkg::DCMP_RET_LOWER, rret);
    chk("write retention", dcmp_pkg::DCMP_RET_HIGHER, wret);
    t_wr(1'b1, 1'b0, 1'b0);
    t_wr(1'b0, 1'b1, 1'b1);
    t_rd(16'd4, 1'b1, 1'b0, 1'b1, 32'd12, 32'd256);
    t_rd(16'd8, 1'b1, 1'b0, 1'b1, 32'd24, 32'd256);
    t_rd(16'd17, 1'b0, 1'b0, 1'b0, 32'd51, 32'd256);
    t_reject();
    t_prog(8'hf8, 8'h20, 16'h0000, 16'h0005, 16'h0009, 16'h0006,
      1'b0);
    chk("read retention", dcmp_pkg::DCMP_RET_RSVD, rret);
    chk("write retention", dcmp_pkg::DCMP_RET_EQUAL, wret);
    t_wr(1'b0, 1'b1, 1'b0);
    t_wr(1'b1, 1'b0, 1'b1);
    t_rd(16'd4, 1'b1, 1'b1, 1'b0, 32'd5, 32'd6);
    complete_run();
  end
endmodule
